/* File: rtl/ehc_homing.sv */
// Homing control for one quadrature encoder channel with reference pulse
`timescale 1ns/1ps
`include "ehc_cfg.svh"
module ehc_homing #(
  parameter int unsigned POS_W        = 16,
  parameter int unsigned CYC_MIN_CLKS = `EHC_CYC_MIN_CLKS,
  parameter int unsigned CYC_MAX_CLKS = `EHC_CYC_MAX_CLKS
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rstn,
  // Encoder side
  input  wire logic              ref_pulse,
  input  wire logic              ref_enable_in,
  // Register writes and bus cycle strobe
  input  wire logic              cfg_wr_en,
  input  wire ehc_pkg::ehc_wr_t  cfg_wr,
  input  wire logic              cycle_tick,
  // Reference value to load
  input  wire logic [POS_W-1:0]  preset_value,
  // Status and position counter load
  output ehc_pkg::ehc_status_t   homing_status,
  output logic                   load_pos,
  output logic [POS_W-1:0]       load_value,
  output logic                   cycle_fault
);

  localparam int unsigned CW = $clog2(CYC_MAX_CLKS + 2);

  ////////////////////////////////////////////////////////////////////////
  // Registers written by the controller, and internal state

  logic [7:0]          reference_enable_select;
  logic [7:0]          reference_enable_level;
  logic [7:0]          reference_edge_select;
  logic [7:0]          referencing_mode;
  ehc_pkg::ehc_state_t state;
  ehc_pkg::ehc_state_t next_state;
  logic                toggle;
  logic                pulse_seen;
  logic [2:0]          pulse_count;
  logic [CW-1:0]       cyc_cnt;
  logic                cyc_seen;
  logic                pulse_det;

  // Write decode; other values of the mode byte are the controller's fault
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reference_enable_select <= `EHC_REN_RST;
      reference_enable_level  <= `EHC_LVL_RST;
      reference_edge_select   <= `EHC_EDGE_RST;
      referencing_mode        <= `EHC_MODE_RST;
    end else if (cfg_wr_en) begin
      unique case (cfg_wr.sel)
        ehc_pkg::EHC_SEL_REN_SELECT: reference_enable_select <= cfg_wr.data;
        ehc_pkg::EHC_SEL_REN_LEVEL:  reference_enable_level  <= cfg_wr.data;
        ehc_pkg::EHC_SEL_EDGE:       reference_edge_select   <= cfg_wr.data;
        ehc_pkg::EHC_SEL_MODE:       referencing_mode        <= cfg_wr.data;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode decode

  // Bit 0 arms homing; 10 has no meaning and counts as off
  function automatic logic mode_on(input logic [7:0] m);
    mode_on = m[`EHC_MODE_ON_BIT];
  endfunction

  function automatic logic mode_cont(input logic [7:0] m);
    mode_cont = m[`EHC_MODE_ON_BIT] & m[`EHC_MODE_CONT_BIT];
  endfunction

  wire logic hom_on   = mode_on(referencing_mode);
  wire logic hom_cont = mode_cont(referencing_mode);

  ////////////////////////////////////////////////////////////////////////
  // Reference pulse detection and enable gating

  ehc_edge u_edge (
    .clock     (clock),
    .rstn      (rstn),
    .ref_pulse (ref_pulse),
    .rising    (reference_edge_select == `EHC_EDGE_RISE),
    .strobe    (pulse_det)
  );

  // Only the exact activate value opens the gate
  wire logic gate_on  = (reference_enable_select == `EHC_REN_ON);
  wire logic level_hi = (reference_enable_level == `EHC_LVL_HIGH);
  wire logic level_ok = level_hi ? ref_enable_in : ~ref_enable_in;
  wire logic qual     = pulse_det & (~gate_on | level_ok);

  // A homing happens on the first accepted pulse, or on each one when continuous
  // Gated by the mode too, so the cycle after writing off cannot still load
  wire logic hom_event = qual & hom_on & ((state == ehc_pkg::EHC_ARMED) |
                                 ((state == ehc_pkg::EHC_DONE) & hom_cont));

  ////////////////////////////////////////////////////////////////////////
  // Homing sequencer

  // Writing off returns to idle, which is how single-shot is rearmed
  always_comb begin
    next_state = state;
    if (!hom_on) begin
      next_state = ehc_pkg::EHC_OFF;
    end else begin
      unique case (state)
        ehc_pkg::EHC_OFF:   next_state = ehc_pkg::EHC_ARMED;
        ehc_pkg::EHC_ARMED: next_state = hom_event ? ehc_pkg::EHC_DONE
                                                   : ehc_pkg::EHC_ARMED;
        ehc_pkg::EHC_DONE:  next_state = ehc_pkg::EHC_DONE;
        default:            next_state = ehc_pkg::EHC_OFF;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= ehc_pkg::EHC_OFF;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags

  // Toggle is cleared when off; a pulse in the same cycle cannot home
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      toggle <= 1'b0;
    end else if (!hom_on) begin
      toggle <= 1'b0;
    end else if (hom_event) begin
      toggle <= ~toggle;
    end
  end

  // Pulse flag and counter survive disabling and count ungated pulses
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pulse_seen  <= 1'b0;
      pulse_count <= 3'h0;
    end else if (pulse_det) begin
      pulse_seen  <= 1'b1;
      pulse_count <= pulse_count + 3'h1;
    end
  end

  wire logic homed = (state == ehc_pkg::EHC_DONE);

  // Zero until a homing completed since arming
  wire ehc_pkg::ehc_status_t next_status = homed ?
    '{pulse_count: pulse_count, pulse_seen: pulse_seen, toggle: toggle,
      homed: 1'b1, rsvd: 2'b00} : '0;

  // Sampled once per bus cycle so the controller sees one coherent byte
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      homing_status <= '0;
    end else if (cycle_tick) begin
      homing_status <= next_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Position counter load

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      load_pos   <= 1'b0;
      load_value <= '0;
    end else begin
      load_pos <= hom_event;
      if (hom_event) begin
        load_value <= preset_value;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus cycle monitor

  wire logic [CW-1:0] cyc_min  = CW'(CYC_MIN_CLKS);
  wire logic [CW-1:0] cyc_max  = CW'(CYC_MAX_CLKS);
  wire logic [CW-1:0] cyc_gap  = cyc_cnt + CW'(1);
  wire logic          cyc_long = cyc_seen & (cyc_cnt >= cyc_max);
  wire logic          cyc_shrt = cyc_seen & (cyc_gap < cyc_min);

  // Once a tick has been seen the counter saturates at the maximum so a stalled bus stays flagged
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cyc_cnt     <= '0;
      cyc_seen    <= 1'b0;
      cycle_fault <= 1'b0;
    end else if (cycle_tick) begin
      cyc_cnt     <= '0;
      cyc_seen    <= 1'b1;
      cycle_fault <= cyc_shrt | cyc_long;
    end else begin
      if (!cyc_long) begin
        cyc_cnt <= cyc_gap;
      end
      if (cyc_long) begin
        cycle_fault <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_armed_pulse;
    hom_on && state == ehc_pkg::EHC_ARMED && qual;
  endsequence

  sequence s_loaded;
    load_pos && load_value == $past(preset_value) && homed;
  endsequence

  property p_first_home;
    s_armed_pulse |=> s_loaded;
  endproperty

  first_home_load_a: assert property (p_first_home)
    else $error("armed pulse did not load preset");

  cont_rehome_a: assert property (
    hom_on && hom_cont && homed && qual |=> load_pos && $changed(toggle))
    else $error("continuous mode missed a reference pulse");

  single_no_rehome_a: assert property (
    hom_on && !hom_cont && homed |=> !load_pos)
    else $error("single shot homed twice");

  toggle_flip_a: assert property (
    hom_on && hom_event |=> toggle != $past(toggle))
    else $error("toggle did not flip on homing");

  disable_clear_a: assert property (
    !hom_on ##1 cycle_tick |=> homing_status[3:0] == 4'h0)
    else $error("status low bits not cleared when off");

  count_keep_a: assert property (
    !pulse_det |=> pulse_count == $past(pulse_count))
    else $error("pulse counter changed without pulse");

  count_step_a: assert property (
    pulse_det |=> pulse_count == $past(pulse_count) + 3'h1 && pulse_seen)
    else $error("pulse counter did not step");

  armed_zero_a: assert property (
    !homed && cycle_tick |=> homing_status == '0)
    else $error("status not zero before homing");

  homed_flag_a: assert property (
    homed && cycle_tick |=> homing_status.homed && homing_status.pulse_seen)
    else $error("homed flags missing");

  gate_block_a: assert property (
    gate_on && pulse_det && (level_hi != ref_enable_in) |=> !load_pos)
    else $error("gated pulse caused homing");

  gate_value_a: assert property (
    reference_enable_select != `EHC_REN_ON && hom_on && state == ehc_pkg::EHC_ARMED &&
      pulse_det |=> load_pos)
    else $error("gate closed while not selected");

  short_cycle_a: assert property (
    cycle_tick && cyc_seen && cyc_cnt < cyc_min - CW'(1) |=> cycle_fault)
    else $error("short bus cycle not flagged");

endmodule

/* File: rtl/ehc_cfg.svh */
// Constants for the encoder homing control block
`ifndef EHC_CFG_SVH
`define EHC_CFG_SVH

// Reference enable select values
`define EHC_REN_OFF      8'h00
`define EHC_REN_ON       8'h08
// Reference enable level values
`define EHC_LVL_LOW      8'h00
`define EHC_LVL_HIGH     8'h08
// Reference edge select values
`define EHC_EDGE_FALL    8'h00
`define EHC_EDGE_RISE    8'h04
// Referencing mode values and field positions
`define EHC_MODE_OFF     8'h00
`define EHC_MODE_SINGLE  8'hC1
`define EHC_MODE_CONT    8'hC3
`define EHC_MODE_ON_BIT  0
`define EHC_MODE_CONT_BIT 1
// Reset values
`define EHC_REN_RST      `EHC_REN_OFF
`define EHC_LVL_RST      `EHC_LVL_LOW
`define EHC_EDGE_RST     `EHC_EDGE_FALL
`define EHC_MODE_RST     `EHC_MODE_OFF
// Bus cycle limits
`define EHC_CLK_MHZ      125
`define EHC_CYC_MIN_US   128
`define EHC_CYC_MAX_MS   16
`define EHC_CYC_MIN_CLKS (`EHC_CYC_MIN_US * `EHC_CLK_MHZ)
`define EHC_CYC_MAX_CLKS (`EHC_CYC_MAX_MS * 1000 * `EHC_CLK_MHZ)

`endif

/* File: rtl/ehc_pkg.sv */
// Types for the encoder homing control block
package ehc_pkg;

  // Homing sequencer, one-hot
  typedef enum logic [2:0] {
    EHC_OFF   = 3'b001,
    EHC_ARMED = 3'b010,
    EHC_DONE  = 3'b100
  } ehc_state_t;

  // Configuration register select
  typedef enum logic [1:0] {
    EHC_SEL_REN_SELECT = 2'h0,
    EHC_SEL_REN_LEVEL  = 2'h1,
    EHC_SEL_EDGE       = 2'h2,
    EHC_SEL_MODE       = 2'h3
  } ehc_sel_t;

  // One register write
  typedef struct packed {
    ehc_sel_t   sel;
    logic [7:0] data;
  } ehc_wr_t;

  // Homing status byte
  typedef struct packed {
    logic [2:0] pulse_count;
    logic       pulse_seen;
    logic       toggle;
    logic       homed;
    logic [1:0] rsvd;
  } ehc_status_t;

endpackage

/* File: rtl/ehc_edge.sv */
// Reference pulse edge detector with selectable polarity
`timescale 1ns/1ps
module ehc_edge (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // Pulse input and edge choice
  input  wire logic ref_pulse,
  input  wire logic rising,
  // One-cycle strobe per selected edge
  output logic      strobe
);

  logic prev;

  // Previous level; low at reset so a high line is no falling edge
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prev <= 1'b0;
    end else begin
      prev <= ref_pulse;
    end
  end

  wire logic rise_w = ref_pulse & ~prev;
  wire logic fall_w = ~ref_pulse & prev;

  // Selected edge, registered
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      strobe <= 1'b0;
    end else begin
      strobe <= rising ? rise_w : fall_w;
    end
  end

endmodule

/* File: tb/ehc_encoder_model.sv */
// Encoder and cyclic controller model facing the homing block
`timescale 1ns/1ps
module ehc_encoder_model (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // Observed load strobe and bus cycle spacing
  input  wire logic       load_pos,
  input  wire logic [7:0] tick_gap,
  // Driven toward the block
  output logic            ref_pulse,
  output logic            cycle_tick
);
  logic [7:0] tick_cnt;

  initial ref_pulse = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // Bus cycle strobe; gap 0 stops the controller to provoke a timeout
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tick_cnt   <= 8'h00;
      cycle_tick <= 1'b0;
    end else if (tick_gap == 8'h00) begin
      tick_cnt   <= 8'h00;
      cycle_tick <= 1'b0;
    end else if (tick_cnt + 8'h01 >= tick_gap) begin
      tick_cnt   <= 8'h00;
      cycle_tick <= 1'b1;
    end else begin
      tick_cnt   <= tick_cnt + 8'h01;
      cycle_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One reference pulse: falling edge, then rising edge; notes loads in each half
  task automatic fire(output logic lo, output logic hi);
    lo = 1'b0;
    hi = 1'b0;
    @(posedge clock);
    ref_pulse <= 1'b0;
    repeat (4) begin
      @(posedge clock);
      #1 if (load_pos === 1'b1) lo = 1'b1;
    end
    @(posedge clock);
    ref_pulse <= 1'b1;
    repeat (4) begin
      @(posedge clock);
      #1 if (load_pos === 1'b1) hi = 1'b1;
    end
  endtask
endmodule

/* File: tb/ehc_homing_tb.sv */
// Self-checking bench for the homing control block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module ehc_homing_tb;
  logic                 clock = 1'b0;
  logic                 rstn = 1'b0;
  logic                 ref_pulse, cycle_tick, load_pos, cycle_fault, lo, hi;
  logic                 ref_enable_in = 1'b1;
  logic                 cfg_wr_en = 1'b0;
  ehc_pkg::ehc_wr_t     cfg_wr = '0;
  ehc_pkg::ehc_status_t homing_status;
  logic [15:0]          preset_value = 16'h0000;
  logic [15:0]          load_value;
  logic [7:0]           tick_gap = 8'h10;
  int                   n_fail = 0;
  int                   n_compared = 0;

  // 125 MHz clock
  always #4 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////
  // Short bus cycle limits keep the timeout checks quick
  ehc_homing #(.POS_W(16), .CYC_MIN_CLKS(8), .CYC_MAX_CLKS(64)) ehc_homing_inst (
    .clock(clock), .rstn(rstn), .ref_pulse(ref_pulse), .ref_enable_in(ref_enable_in),
    .cfg_wr_en(cfg_wr_en), .cfg_wr(cfg_wr), .cycle_tick(cycle_tick),
    .preset_value(preset_value), .homing_status(homing_status), .load_pos(load_pos),
    .load_value(load_value), .cycle_fault(cycle_fault));

  ehc_encoder_model ehc_encoder_model_inst (
    .clock(clock), .rstn(rstn), .load_pos(load_pos), .tick_gap(tick_gap),
    .ref_pulse(ref_pulse), .cycle_tick(cycle_tick));

  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // One register write, strobe for a single cycle
  task automatic wr(input logic [1:0] sel, input logic [7:0] data);
    @(posedge clock);
    cfg_wr_en <= 1'b1;
    cfg_wr    <= '{sel: ehc_pkg::ehc_sel_t'(sel), data: data};
    @(posedge clock);
    cfg_wr_en <= 1'b0;
  endtask

  // Wait for n bus cycles, bounded
  task automatic ticks(input int n);
    int seen;
    seen = 0;
    for (int i = 0; i < 300 && seen < n; i++) begin
      @(posedge clock);
      #1 if (cycle_tick === 1'b1) seen++;
    end
    if (seen < n) begin
      n_fail++;
      $display("ERROR cycle_tick expected %0d seen %0d", n, seen);
      end_of_test();
    end
    @(posedge clock);
    #1;
  endtask

  // Pulse, check loads in each half, then the refreshed status
  task automatic pulse(input logic elo, input logic ehi, input logic [7:0] est);
    ehc_encoder_model_inst.fire(lo, hi);
    `CHK("load_fall", elo, lo)
    `CHK("load_rise", ehi, hi)
    if (lo | hi) `CHK("load_value", preset_value, load_value)
    ticks(2);
    `CHK("homing_status", est, homing_status)
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_single;
    preset_value <= 16'h1234;
    wr(2'h3, 8'hC1);
    ticks(2);
    `CHK("armed_status", 8'h00, homing_status)
    pulse(1'b1, 1'b0, 8'h3C);
    pulse(1'b0, 1'b0, 8'h5C);
    $display("single-shot done");
  endtask

  task automatic t_restart;
    wr(2'h3, 8'h00);
    ticks(2);
    `CHK("off_status", 8'h00, homing_status)
    wr(2'h3, 8'hC1);
    pulse(1'b1, 1'b0, 8'h7C);
    $display("restart done");
  endtask

  task automatic t_cont;
    wr(2'h3, 8'h00);
    preset_value <= 16'h0ABC;
    wr(2'h3, 8'hC3);
    pulse(1'b1, 1'b0, 8'h9C);
    pulse(1'b1, 1'b0, 8'hB4);
    $display("continuous done");
  endtask

  // Gate open, active high, then active low, then gate closed again
  task automatic t_gate;
    wr(2'h0, 8'h08);
    wr(2'h1, 8'h08);
    ref_enable_in <= 1'b0;
    pulse(1'b0, 1'b0, 8'hD4);
    ref_enable_in <= 1'b1;
    pulse(1'b1, 1'b0, 8'hFC);
    wr(2'h1, 8'h00);
    ref_enable_in <= 1'b0;
    pulse(1'b1, 1'b0, 8'h14);
    wr(2'h0, 8'h00);
    ref_enable_in <= 1'b1;
    pulse(1'b1, 1'b0, 8'h3C);
    $display("enable gate done");
  endtask

  task automatic t_edge;
    wr(2'h2, 8'h04);
    pulse(1'b0, 1'b1, 8'h54);
    $display("rising edge done");
  endtask

  task automatic t_cycle;
    tick_gap <= 8'h04;
    ticks(3);
    `CHK("fault_short", 1'b1, cycle_fault)
    // Clear the fault first so the stall check below can really trip
    tick_gap <= 8'h10;
    ticks(2);
    `CHK("fault_clear", 1'b0, cycle_fault)
    tick_gap <= 8'h00;
    repeat (80) @(posedge clock);
    #1 `CHK("fault_long", 1'b1, cycle_fault)
    tick_gap <= 8'h10;
    ticks(2);
    `CHK("fault_recover", 1'b0, cycle_fault)
    $display("bus cycle done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    #1 `CHK("reset_status", 8'h00, homing_status)
    `CHK("reset_load", 1'b0, load_pos)
    t_single();
    t_restart();
    t_cont();
    t_gate();
    t_edge();
    t_cycle();
    end_of_test();
  end
endmodule
